/* design/pam_alert_mask.sv */
// Purpose: alert mask registers, access decode and alert line drive
// Assumes: request strobes and status bits come from same-clock logic
// Notes:   answers and mask updates appear one clock after the request
`timescale 1ns/1ps

module pam_alert_mask
(
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	// word write from the protocol engine
	input  wire logic        i_wr_vld,
	input  wire logic [7:0]  i_wr_cmd,
	input  wire logic [7:0]  i_wr_lo,
	input  wire logic [7:0]  i_wr_hi,
	// process call read from the protocol engine
	input  wire logic        i_rd_vld,
	input  wire logic [7:0]  i_rd_cmd,
	input  wire logic [7:0]  i_rd_sel,
	// current phase selection
	input  wire logic [7:0]  i_phase,
	// nonvolatile restore of mask values
	input  wire logic        i_nvm_load,
	input  wire logic [7:0]  i_nvm_vout,
	input  wire logic [7:0]  i_nvm_iout,
	input  wire logic [7:0]  i_nvm_input,
	input  wire logic [7:0]  i_nvm_temp,
	// live status bits of each group
	input  wire logic [7:0]  i_status_vout,
	input  wire logic [7:0]  i_status_iout,
	input  wire logic [7:0]  i_status_input,
	input  wire logic [7:0]  i_status_temp,
	// read answer
	output logic             o_rd_vld,
	output logic [7:0]       o_rd_data,
	// communication error pulse
	output logic             o_cml_invalid,
	// alert line, open drain
	output logic             o_alert_out,
	output logic             o_alert_oe,
	// mask values seen by the converter
	output logic [7:0]       o_output_voltage_alert_mask,
	output logic [7:0]       o_output_current_alert_mask,
	output logic [7:0]       o_input_alert_mask,
	output logic [7:0]       o_temp_alert_mask
);
	import pam_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0] vout;
		logic [7:0] iout;
		logic [7:0] inp;
		logic [7:0] temp;
		logic       rd_vld;
		logic [7:0] rd_data;
		logic       err;
		logic       alert;
	} pam_state_t;

	pam_state_t st_reg;
	pam_state_t st_next;

	// ==========================================================
	// helpers
	function automatic logic pam_sel_ok(input logic [7:0] sel);
		pam_sel_ok = (sel == PAM_SEL_VOUT) || (sel == PAM_SEL_IOUT) ||
			(sel == PAM_SEL_INPUT) || (sel == PAM_SEL_TEMP);
	endfunction : pam_sel_ok

	function automatic logic [7:0] pam_mask_of(input pam_state_t s,
		input logic [7:0] sel);
		case (sel)
			PAM_SEL_VOUT:  pam_mask_of = s.vout;
			PAM_SEL_IOUT:  pam_mask_of = s.iout;
			PAM_SEL_INPUT: pam_mask_of = s.inp;
			PAM_SEL_TEMP:  pam_mask_of = s.temp;
			default:       pam_mask_of = PAM_RST_DATA;
		endcase
	endfunction : pam_mask_of

	logic wr_hit;
	logic wr_ok;
	logic rd_hit;
	logic rd_ok;
	logic unmasked;

	assign wr_hit = i_wr_vld && (i_wr_cmd == PAM_CMD_ALERT_MASK);
	assign rd_hit = i_rd_vld && (i_rd_cmd == PAM_CMD_ALERT_MASK);
	// access only while all phases are addressed
	assign wr_ok  = wr_hit && (i_phase == PAM_PHASE_ALL) && // RL4
		pam_sel_ok(i_wr_lo); // RL12
	assign rd_ok  = rd_hit && (i_phase == PAM_PHASE_ALL) && // RL4
		pam_sel_ok(i_rd_sel);
	// status bits are left untouched; only their alert path is gated
	assign unmasked = |(i_status_vout  & ~st_reg.vout) || // RL1 RL5 RL11
		|(i_status_iout  & ~st_reg.iout) ||
		|(i_status_input & ~st_reg.inp)  ||
		|(i_status_temp  & ~st_reg.temp);

	// ==========================================================
	// next state
	always_comb
	begin
		st_next        = st_reg;
		st_next.rd_vld = 1'b0;
		st_next.err    = 1'b0;
		st_next.alert  = unmasked; // RL11
		if (i_nvm_load)
		begin
			st_next.vout = i_nvm_vout & PAM_IMPL_VOUT;
			st_next.iout = i_nvm_iout & PAM_IMPL_IOUT;
			st_next.inp  = (st_reg.inp & ~PAM_NVM_INPUT) |
				(i_nvm_input & PAM_NVM_INPUT);
			st_next.temp = i_nvm_temp & PAM_IMPL_TEMP;
		end
		else if (wr_ok)
		begin
			case (i_wr_lo) // RL2
				PAM_SEL_VOUT:  st_next.vout = i_wr_hi & PAM_IMPL_VOUT; // RL6 RL7
				PAM_SEL_IOUT:  st_next.iout = i_wr_hi & PAM_IMPL_IOUT; // RL8
				PAM_SEL_INPUT: st_next.inp  = i_wr_hi & PAM_IMPL_INPUT; // RL9
				PAM_SEL_TEMP:  st_next.temp = i_wr_hi & PAM_IMPL_TEMP; // RL10
				default:       st_next.vout = st_reg.vout;
			endcase
		end
		if (wr_hit && !wr_ok)
		begin
			st_next.err = 1'b1; // RL12
		end
		if (rd_hit)
		begin
			st_next.rd_vld  = 1'b1; // RL3
			st_next.rd_data = rd_ok ? pam_mask_of(st_reg, i_rd_sel) :
				PAM_RST_DATA;
			if (!rd_ok)
			begin
				st_next.err = 1'b1;
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_reg.vout    <= PAM_RST_MASK;
			st_reg.iout    <= PAM_RST_MASK;
			st_reg.inp     <= PAM_RST_MASK; // RL9
			st_reg.temp    <= PAM_RST_MASK;
			st_reg.rd_vld  <= 1'b0;
			st_reg.rd_data <= PAM_RST_DATA;
			st_reg.err     <= 1'b0;
			st_reg.alert   <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	assign o_rd_vld                    = st_reg.rd_vld;
	assign o_rd_data                   = st_reg.rd_data;
	assign o_cml_invalid               = st_reg.err;
	assign o_alert_out                 = 1'b0;
	assign o_alert_oe                  = st_reg.alert;
	assign o_output_voltage_alert_mask = st_reg.vout;
	assign o_output_current_alert_mask = st_reg.iout;
	assign o_input_alert_mask          = st_reg.inp;
	assign o_temp_alert_mask           = st_reg.temp;

	// ==========================================================
	// checks
	default clocking pam_cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);

	sequence seq_wr(logic [7:0] sel);
		wr_hit && !i_nvm_load && (i_phase == PAM_PHASE_ALL) &&
			(i_wr_lo == sel);
	endsequence

	sequence seq_masks_hold;
		$stable(st_reg.vout) && $stable(st_reg.iout) &&
			$stable(st_reg.inp) && $stable(st_reg.temp);
	endsequence

	sequence seq_rd(logic [7:0] sel);
		rd_hit && !wr_hit && (i_phase == PAM_PHASE_ALL) &&
			(i_rd_sel == sel);
	endsequence

	sequence seq_rd_answer(logic [7:0] val);
		o_rd_vld && !o_cml_invalid && (o_rd_data == val);
	endsequence

	a_vout_write: assert property ( // RL2 RL6
		seq_wr(PAM_SEL_VOUT) |=>
			o_output_voltage_alert_mask == ($past(i_wr_hi) & 8'hFC))
		else $error("output voltage mask not written");

	a_vout_low_zero: assert property ( // RL7
		o_output_voltage_alert_mask[1:0] == 2'h0)
		else $error("output voltage mask low bits not zero");

	a_iout_layout: assert property ( // RL8
		seq_wr(PAM_SEL_IOUT) |=>
			o_output_current_alert_mask == ($past(i_wr_hi) & 8'hB0))
		else $error("output current mask layout wrong");

	a_input_layout: assert property ( // RL9
		seq_wr(PAM_SEL_INPUT) |=>
			o_input_alert_mask == ($past(i_wr_hi) & 8'hE8))
		else $error("input mask layout wrong");

	a_temp_write: assert property ( // RL10
		seq_wr(PAM_SEL_TEMP) |=>
			o_temp_alert_mask == ($past(i_wr_hi) & 8'hC0))
		else $error("temperature mask not written");

	a_phase_block: assert property ( // RL4
		(wr_hit && !i_nvm_load && i_phase != 8'hFF) |=>
			seq_masks_hold ##0 o_cml_invalid)
		else $error("mask changed while not all phases addressed");

	a_read_answer: assert property ( // RL3 RL6
		seq_rd(PAM_SEL_VOUT) |=>
			seq_rd_answer($past(o_output_voltage_alert_mask)))
		else $error("voltage mask read back wrong");

	a_read_iout: assert property ( // RL3 RL8
		seq_rd(PAM_SEL_IOUT) |=>
			seq_rd_answer($past(o_output_current_alert_mask)))
		else $error("current mask read back wrong");

	a_read_input: assert property ( // RL3 RL9
		seq_rd(PAM_SEL_INPUT) |=>
			seq_rd_answer($past(o_input_alert_mask)))
		else $error("input mask read back wrong");

	a_read_temp: assert property ( // RL3 RL10
		seq_rd(PAM_SEL_TEMP) |=>
			seq_rd_answer($past(o_temp_alert_mask)))
		else $error("temperature mask read back wrong");

	a_read_pulse: assert property ( // RL3
		o_rd_vld |=> !o_rd_vld || $past(rd_hit))
		else $error("read answer stood longer than one cycle");

	a_read_refuse: assert property ( // RL4 RL12
		(rd_hit && !rd_ok) |=>
			o_rd_vld && (o_rd_data == 8'h00) && o_cml_invalid)
		else $error("refused read not answered with zero and error");

	a_alert_drive: assert property ( // RL5 RL11
		o_alert_oe == $past(unmasked))
		else $error("alert line not following unmasked status");

	a_mask_gates: assert property ( // RL1
		(i_status_vout != 8'h00 && (i_status_vout & ~st_reg.vout) == 8'h00
		&& i_status_iout == 8'h00 && i_status_input == 8'h00 &&
		i_status_temp == 8'h00) |=> !o_alert_oe)
		else $error("masked condition drove the alert line");

	a_bad_selector: assert property ( // RL12
		(wr_hit && !i_nvm_load && !pam_sel_ok(i_wr_lo)) |=>
			seq_masks_hold ##0 o_cml_invalid)
		else $error("unknown selector not rejected");

	a_iout_unused_zero: assert property ( // RL8
		(o_output_current_alert_mask & 8'h4F) == 8'h00)
		else $error("output current mask unused bits not zero");

	a_input_unused_zero: assert property ( // RL9
		(o_input_alert_mask & 8'h17) == 8'h00)
		else $error("input mask unused bits not zero");

	a_temp_unused_zero: assert property ( // RL10
		(o_temp_alert_mask & 8'h3F) == 8'h00)
		else $error("temperature mask unused bits not zero");

	a_nvm_input_keep: assert property ( // RL9
		i_nvm_load |=>
			(o_input_alert_mask[7:5] == $past(o_input_alert_mask[7:5])) &&
			(o_input_alert_mask[3] == $past(i_nvm_input[3])))
		else $error("restore touched the input warning masks");

	a_vout_restore: assert property ( // RL6 RL7
		i_nvm_load |=>
			o_output_voltage_alert_mask == ($past(i_nvm_vout) & 8'hFC))
		else $error("voltage mask not restored");

	a_write_others: assert property ( // RL2
		seq_wr(PAM_SEL_VOUT) |=>
			$stable(st_reg.iout) && $stable(st_reg.inp) &&
			$stable(st_reg.temp))
		else $error("write to one group changed another");

	a_write_quiet: assert property ( // RL12
		(wr_ok && !rd_hit) |=> !o_cml_invalid)
		else $error("valid write flagged as an error");

	a_alert_unmasked: assert property ( // RL11
		((i_status_iout & ~st_reg.iout) != 8'h00) |=> o_alert_oe)
		else $error("unmasked current condition did not alert");

endmodule : pam_alert_mask

/* design/pam_pkg.sv */
// Purpose: constants for the alert mask unit of a bus-managed converter
// Assumes: the bus protocol engine decodes frames on the same clock
// Notes:   mask values come from nonvolatile memory on a load pulse, except input bits 7..5, which keep their value
//
// Behaviour
// (RL1) masking never stops a status bit setting; it only gates the alert
// (RL2) word write to 1Bh: low byte selects group, high byte is mask
// (RL3) process call with one-byte selector returns that group's mask byte
// (RL4) mask access accepted only while phase selects all phases
// (RL5) mask bit zero lets condition alert, one blocks it
// (RL6) selector 7Ah: output-voltage mask, bits 7 to 2
// (RL7) output-voltage mask bits 1 and 0 always read zero
// (RL8) selector 7Bh: output-current mask bits 7, 5, 4; bits 6, 3 zero
// (RL9) selector 7Ch: input mask bits 7..5 reset zero, bit 3 low input
// (RL10) selector 7Dh: temperature mask group, same access protocol
// (RL11) alert asserts while any status bit is set with mask zero
// (RL12) unknown selector: masks unchanged, communication error flagged
package pam_pkg;

	// ==========================================================
	// command codes and selectors
	localparam logic [7:0] PAM_CMD_ALERT_MASK = 8'h1B;
	localparam logic [7:0] PAM_PHASE_ALL      = 8'hFF;
	localparam logic [7:0] PAM_SEL_VOUT       = 8'h7A;
	localparam logic [7:0] PAM_SEL_IOUT       = 8'h7B;
	localparam logic [7:0] PAM_SEL_INPUT      = 8'h7C;
	localparam logic [7:0] PAM_SEL_TEMP       = 8'h7D;

	// ==========================================================
	// implemented bits of each group
	localparam logic [7:0] PAM_IMPL_VOUT      = 8'hFC;
	localparam logic [7:0] PAM_IMPL_IOUT      = 8'hB0;
	localparam logic [7:0] PAM_IMPL_INPUT     = 8'hE8;
	localparam logic [7:0] PAM_IMPL_TEMP      = 8'hC0;
	// input group bits that are loaded from nonvolatile memory
	localparam logic [7:0] PAM_NVM_INPUT      = 8'h08;

	// ==========================================================
	// field positions
	localparam int PAM_BIT_OUT_OVERVOLT_FAULT = 7;
	localparam int PAM_BIT_OUT_OVERVOLT_WARN  = 6;
	localparam int PAM_BIT_OUT_UNDERVOLT_WARN = 5;
	localparam int PAM_BIT_OUT_UNDERVOLT_FAULT = 4;
	localparam int PAM_BIT_OUT_LIMIT_VIOL     = 3;
	localparam int PAM_BIT_TURN_ON_TIMEOUT    = 2;
	localparam int PAM_BIT_OVERCURRENT_FAULT  = 7;
	localparam int PAM_BIT_OVERCURRENT_WARN   = 5;
	localparam int PAM_BIT_UNDERCURRENT_FAULT = 4;
	localparam int PAM_BIT_LOW_INPUT          = 3;

	// ==========================================================
	// values after reset
	localparam logic [7:0] PAM_RST_MASK       = 8'h00;
	localparam logic [7:0] PAM_RST_DATA       = 8'h00;

endpackage : pam_pkg

/* bench/pam_host.sv */
// Purpose: host model issuing mask writes and process-call reads
// Assumes: requests change 1 ns after the rising clock edge
// Notes:   the bench calls put by hierarchical name
`timescale 1ns/1ps

module pam_host
(
	// clock
	input  wire logic       i_mclk,
	// read answer
	input  wire logic       i_rd_vld,
	input  wire logic [7:0] i_rd_data,
	// requests
	output logic            o_wr_vld,
	output logic            o_rd_vld,
	output logic [7:0]      o_cmd,
	output logic [7:0]      o_lo,
	output logic [7:0]      o_hi
);
	import pam_pkg::*;

	initial
	begin
		o_wr_vld = 1'b0;
		o_rd_vld = 1'b0;
		o_cmd    = 8'h00;
		o_lo     = 8'h00;
		o_hi     = 8'h00;
	end

	// an idle edge first, so a strobe never falls and rises in one step;
	// then one request held for one edge; released data shows the inverse
	task automatic put(input logic w, input logic [7:0] s, m,
		output logic v, output logic [7:0] d);
		@(posedge i_mclk);
		#1;
		o_wr_vld = w;
		o_rd_vld = !w;
		o_cmd    = PAM_CMD_ALERT_MASK;
		o_lo     = s;
		o_hi     = m;
		@(posedge i_mclk);
		#1;
		v        = i_rd_vld;
		d        = i_rd_data;
		o_wr_vld = 1'b0;
		o_rd_vld = 1'b0;
		o_cmd    = ~o_cmd;
		o_lo     = ~o_lo;
		o_hi     = ~o_hi;
	endtask : put
endmodule : pam_host

/* bench/tb.sv */
// Purpose: self-checking bench for the alert mask unit
// Assumes: inputs change 1 ns after the rising clock edge
// Notes:   expectations come from the group bit layouts
`timescale 1ns/1ps

module tb;
	import pam_pkg::*;
	logic       i_mclk   = 1'b0;
	logic       i_arst_n = 1'b0;
	logic       wv, rv, ld = 1'b0, v, ov, er, ao, oe;
	logic [7:0] cmd, lo, hi, ph = 8'hFF, nv = 8'h00, od, d;
	logic [7:0] st [4] = '{default: 8'h00};
	wire  [3:0][7:0] mk;
	logic [7:0] sl [4] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D};
	logic [7:0] im [4] = '{PAM_IMPL_VOUT, PAM_IMPL_IOUT, PAM_IMPL_INPUT,
		PAM_IMPL_TEMP};
	int         n_mismatch  = 0;
	int         checks_done = 0;

	always #2 i_mclk = ~i_mclk;

	pam_host host (.i_mclk(i_mclk), .i_rd_vld(ov), .i_rd_data(od),
		.o_wr_vld(wv), .o_rd_vld(rv), .o_cmd(cmd), .o_lo(lo), .o_hi(hi));

	pam_alert_mask dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
		.i_wr_vld(wv), .i_wr_cmd(cmd), .i_wr_lo(lo), .i_wr_hi(hi),
		.i_rd_vld(rv), .i_rd_cmd(cmd), .i_rd_sel(lo), .i_phase(ph),
		.i_nvm_load(ld), .i_nvm_vout(nv), .i_nvm_iout(nv),
		.i_nvm_input(nv), .i_nvm_temp(nv), .i_status_vout(st[0]),
		.i_status_iout(st[1]), .i_status_input(st[2]),
		.i_status_temp(st[3]), .o_rd_vld(ov), .o_rd_data(od),
		.o_cml_invalid(er), .o_alert_out(ao), .o_alert_oe(oe),
		.o_output_voltage_alert_mask(mk[0]),
		.o_output_current_alert_mask(mk[1]),
		.o_input_alert_mask(mk[2]), .o_temp_alert_mask(mk[3]));

	task automatic check(input string n, input logic [7:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task automatic step();
		@(posedge i_mclk);
		#1;
	endtask : step

	// ==========================================================
	// scenarios
	task automatic t_layout();
		for (int i = 0; i < 4; i++)
		begin
			check("reset mask", mk[i], PAM_RST_MASK);
			host.put(1'b1, sl[i], 8'hFF, v, d);
			check("mask", mk[i], im[i]);
			host.put(1'b0, sl[i], 8'h00, v, d);
			check("rd vld", {7'h00, v}, 8'h01);
			check("rd data", d, im[i]);
			check("no error", {7'h00, er}, 8'h00);
			host.put(1'b1, sl[i], 8'h00, v, d);
			check("cleared", mk[i], 8'h00);
		end
	endtask : t_layout

	task automatic t_refuse();
		ph = 8'h00;
		host.put(1'b1, sl[0], 8'hFF, v, d);
		check("phase wr err", {7'h00, er}, 8'h01);
		check("phase wr mask", mk[0], 8'h00);
		host.put(1'b0, sl[0], 8'h00, v, d);
		check("phase rd", {6'h00, er, v}, 8'h03);
		check("phase rd data", d, 8'h00);
		ph = 8'hFF;
		host.put(1'b1, 8'h7E, 8'hFF, v, d);
		check("bad sel err", {7'h00, er}, 8'h01);
		host.put(1'b0, 8'h7E, 8'h00, v, d);
		check("bad sel rd", {6'h00, er, v}, 8'h03);
		check("bad sel rd data", d, 8'h00);
		for (int i = 0; i < 4; i++)
			check("bad sel mask", mk[i], 8'h00);
	endtask : t_refuse

	task automatic t_nvm();
		nv = 8'hFF;
		ld = 1'b1;
		step();
		ld = 1'b0;
		for (int i = 0; i < 4; i++)
			check("nvm", mk[i],
				im[i] & (i == 2 ? PAM_NVM_INPUT : 8'hFF));
	endtask : t_nvm

	task automatic t_alert();
		for (int i = 0; i < 4; i++)
		begin
			host.put(1'b1, sl[i], 8'hFF, v, d);
			st[i] = im[i];
			step();
			step();
			check("masked", {6'h00, ao, oe}, 8'h00);
			host.put(1'b1, sl[i], 8'h00, v, d);
			step();
			check("alert", {6'h00, ao, oe}, 8'h01);
			st[i] = 8'h00;
			step();
			step();
			check("quiet", {7'h00, oe}, 8'h00);
		end
	endtask : t_alert

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (20) @(posedge i_mclk);
		#1;
		i_arst_n = 1'b1;
		step();
		t_layout();
		t_refuse();
		t_nvm();
		t_alert();
		conclude();
	end
endmodule : tb
